// ==== verilog/dctpd_defs.svh ====
`ifndef DCTPD_DEFS_SVH
`define DCTPD_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets inside expanded bank d
// ----------------------------------------------------------------------
`define DCTPD_OFS_BYTE_CTL  4'h0
`define DCTPD_OFS_SHARED    4'h1
`define DCTPD_OFS_WORD_CTL  4'h2
`define DCTPD_OFS_SYNC      4'h3
`define DCTPD_OFS_BHOLD_LO  4'h4
`define DCTPD_OFS_BHOLD_HI  4'h5
`define DCTPD_OFS_WHOLD_LO  4'h6
`define DCTPD_OFS_WHOLD_UP  4'h7
`define DCTPD_OFS_CAP_LO    4'h8
`define DCTPD_OFS_CAP_UP    4'h9

// ----------------------------------------------------------------------
// field positions of the byte and word control registers
// ----------------------------------------------------------------------
`define DCTPD_B_RUN     7
`define DCTPD_B_SINGLE  6
`define DCTPD_B_TOUT    5
`define DCTPD_B_RATE_HI 4
`define DCTPD_B_RATE_LO 3
`define DCTPD_B_CAPM    2
`define DCTPD_B_TOUTM   1
`define DCTPD_B_ROUTE   0

// ----------------------------------------------------------------------
// field positions of the shared and sync control registers
// ----------------------------------------------------------------------
`define DCTPD_B_DEMOD    6
`define DCTPD_B_EDGE_HI  5
`define DCTPD_B_EDGE_LO  4
`define DCTPD_B_FORCE_HI 3
`define DCTPD_B_FORCE_LO 2
`define DCTPD_B_INIT8    1
`define DCTPD_B_INIT16   0
`define DCTPD_B_SYNC_W   7
`define DCTPD_B_SYNC_B   6
`define DCTPD_B_SYNC_EN  5

// ----------------------------------------------------------------------
// constant values
// ----------------------------------------------------------------------
`define DCTPD_BYTE_ZERO 8'h00
`define DCTPD_BYTE_ONE  8'h01
`define DCTPD_WORD_ZERO 16'h0000
`define DCTPD_WORD_ONE  16'h0001
`define DCTPD_WORD_ONES 16'hffff
`define DCTPD_RATE_ZERO 2'h0
`define DCTPD_FORCE_LOW 2'h2
`define DCTPD_FORCE_HIGH 2'h3
`define DCTPD_DIV_ZERO  3'h0
`define DCTPD_DIV_ONE   3'h1

`endif

// ==== verilog/dctpd_pkg.sv ====
package dctpd_pkg;

  // edge qualifier codes of the demodulation input
  typedef enum logic [1:0] {
    DCTPD_EDGE_NONE = 2'b00,
    DCTPD_EDGE_RISE = 2'b01,
    DCTPD_EDGE_FALL = 2'b10,
    DCTPD_EDGE_BOTH = 2'b11
  } dctpd_edge_e;

  // phases of the word counter in demodulation operation
  typedef enum logic [1:0] {
    DCTPD_DM_IDLE    = 2'b00,
    DCTPD_DM_FIRST   = 2'b01,
    DCTPD_DM_MEASURE = 2'b10
  } dctpd_phase_e;

endpackage

// ==== verilog/dctpd_top.sv ====
`timescale 1ns/1ps
`include "dctpd_defs.svh"

// Functional notes
// - writing run bit 1 starts word counter, 0 stops; read shows running state
// - transmit: repeat-select 0 reloads at terminal count, 1 halts there
// - demodulation: repeat-select 0 acts on every edge, 1 only first edge
// - word timeout flag sets at terminal count; write 1 clears, 0 ignored
// - capture mask gates the capture interrupt request
// - word timeout mask gates the word timeout interrupt request
// - route bit picks port latch or word counter wave for shared pin
// - reset initialises fields; recovery keeps rates, capture masks, sync mode
// - byte start: wave takes initial level, loads low or high hold
// - byte single-pass: count to 0, stop, toggle, flag, optional interrupt
// - byte modulo-N: first terminal toggles silently, later ones flag, interrupt if enabled
// - byte modulo-N reloads low hold at level 0, high hold at 1
// - hold registers may change anytime; new values apply at next load
// - byte initial count 0 wraps to ff and keeps counting
// - idle word wave is inverse of its initial-level bit
// - force code 10 or 11 drives word wave 0 or 1 always
// - word start loads upper*256+lower and sets initial level
// - word terminal count toggles wave, sets flag, interrupt if enabled
// - word single-pass stops after timeout, modulo-N reloads and continues
// - word initial count 0 wraps to ffff without timeout
// - first qualifying edge captures, reloads and starts counting
// - later edges capture complemented count, set edge flag, interrupt if enabled
// - after each later capture word counter reloads ffff; the first capture reloads the hold
// - registers sit in expanded bank d at their printed offsets
module dctpd_top (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       recover_i,
  // register file port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // pins
  input  wire logic       port_latch_i,
  input  wire logic       demod_in_i,
  output logic            byte_counter_wave_o,
  output logic            word_counter_wave_o,
  output logic            shared_port_pin_o,
  // interrupt requests
  output logic            irq_byte_timeout_o,
  output logic            irq_word_timeout_o,
  output logic            irq_capture_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic        byte_run, byte_single, byte_tout, byte_capm, byte_toutm, byte_first;
  logic [1:0]  byte_rate, word_rate, wave_force;
  logic        word_run_bit, word_single, word_tout, word_capm, word_toutm;
  logic        wave_pin_route, sync_mode, demod_mode, init8, init16;
  logic        edge_rise_flag, edge_fall_flag, demod_prev, byte_wave, word_wave;
  logic [1:0]  edge_sel;
  logic [7:0]  byte_hold_low, byte_hold_high, byte_cnt;
  logic [7:0]  word_hold_lower, word_hold_upper;
  logic [15:0] word_cnt, capture_word;
  logic [2:0]  div_cnt;
  dctpd_pkg::dctpd_phase_e phase;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic wr_byte, wr_shared, wr_word, wr_sync;
  logic byte_en_wr, byte_en_val, word_en_wr, word_en_val;
  logic byte_start, byte_stop, word_start, word_stop;
  logic byte_tick, word_tick, byte_term, byte_ev, word_ev;
  logic rise, fall, qual, cap_any, cap_later;
  logic wave_eff;
  logic [15:0] word_hold;

  // bank d decode at the printed offsets
  assign wr_byte   = reg_wr_i && (reg_addr_i == `DCTPD_OFS_BYTE_CTL);
  assign wr_shared = reg_wr_i && (reg_addr_i == `DCTPD_OFS_SHARED);
  assign wr_word   = reg_wr_i && (reg_addr_i == `DCTPD_OFS_WORD_CTL);
  assign wr_sync   = reg_wr_i && (reg_addr_i == `DCTPD_OFS_SYNC);

  // in sync mode only the sync register starts or stops the counters, so
  // both begin on the same clock
  assign byte_en_wr  = (wr_byte && !sync_mode) || wr_sync;
  assign byte_en_val = wr_sync ? reg_wdata_i[`DCTPD_B_SYNC_B] : reg_wdata_i[`DCTPD_B_RUN];
  assign word_en_wr  = (wr_word && !sync_mode) || wr_sync;
  assign word_en_val = wr_sync ? reg_wdata_i[`DCTPD_B_SYNC_W] : reg_wdata_i[`DCTPD_B_RUN];
  // a running counter is not restarted, so flag clears keep it counting
  assign byte_start  = byte_en_wr && byte_en_val && !byte_run;
  assign byte_stop   = byte_en_wr && !byte_en_val;
  assign word_start  = word_en_wr && word_en_val && !word_run_bit;
  assign word_stop   = word_en_wr && !word_en_val;

  // ----------------------------------------------------------------------
  // rate divider
  // ----------------------------------------------------------------------
  function automatic logic rate_tick(input logic [1:0] rate, input logic [2:0] div);
    case (rate)
      2'h0:    rate_tick = 1'b1;
      2'h1:    rate_tick = div[0];
      2'h2:    rate_tick = &div[1:0];
      default: rate_tick = &div;
    endcase
  endfunction

  // free running; one shared divider keeps both counters phase aligned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= `DCTPD_DIV_ZERO;
    end else begin
      div_cnt <= div_cnt + `DCTPD_DIV_ONE;
    end
  end

  assign byte_tick = rate_tick(byte_rate, div_cnt);
  assign word_tick = rate_tick(word_rate, div_cnt);

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  // preserved fields only clear on power-on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_rate  <= `DCTPD_RATE_ZERO;
      word_rate  <= `DCTPD_RATE_ZERO;
      byte_capm  <= 1'b0;
      word_capm  <= 1'b0;
      sync_mode  <= 1'b0;
    end else begin
      if (wr_byte) begin
        byte_rate <= reg_wdata_i[`DCTPD_B_RATE_HI:`DCTPD_B_RATE_LO];
        byte_capm <= reg_wdata_i[`DCTPD_B_CAPM];
      end
      if (wr_word) begin
        word_rate <= reg_wdata_i[`DCTPD_B_RATE_HI:`DCTPD_B_RATE_LO];
        word_capm <= reg_wdata_i[`DCTPD_B_CAPM];
      end
      if (wr_sync) begin
        sync_mode <= reg_wdata_i[`DCTPD_B_SYNC_EN];
      end
    end
  end

  // plain fields clear on reset and on stop-mode recovery
  always_ff @(posedge clk_i) begin
    if (rst_i || recover_i) begin
      byte_single    <= 1'b0;
      byte_toutm     <= 1'b0;
      word_single    <= 1'b0;
      word_toutm     <= 1'b0;
      wave_pin_route <= 1'b0;
      demod_mode     <= 1'b0;
      edge_sel       <= dctpd_pkg::DCTPD_EDGE_NONE;
      wave_force     <= `DCTPD_RATE_ZERO;
      init8          <= 1'b0;
      init16         <= 1'b0;
    end else begin
      if (wr_byte) begin
        byte_single <= reg_wdata_i[`DCTPD_B_SINGLE];
        byte_toutm  <= reg_wdata_i[`DCTPD_B_TOUTM];
      end
      if (wr_word) begin
        word_single    <= reg_wdata_i[`DCTPD_B_SINGLE];
        word_toutm     <= reg_wdata_i[`DCTPD_B_TOUTM];
        wave_pin_route <= reg_wdata_i[`DCTPD_B_ROUTE];
      end
      if (wr_shared) begin
        demod_mode <= reg_wdata_i[`DCTPD_B_DEMOD];
        edge_sel   <= reg_wdata_i[`DCTPD_B_EDGE_HI:`DCTPD_B_EDGE_LO];
        wave_force <= reg_wdata_i[`DCTPD_B_FORCE_HI:`DCTPD_B_FORCE_LO];
        // in demodulation the low bits address the edge flags instead
        if (!reg_wdata_i[`DCTPD_B_DEMOD]) begin
          init8  <= reg_wdata_i[`DCTPD_B_INIT8];
          init16 <= reg_wdata_i[`DCTPD_B_INIT16];
        end
      end
    end
  end

  // hold registers; written values only reach a counter at its next load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_hold_low   <= `DCTPD_BYTE_ZERO;
      byte_hold_high  <= `DCTPD_BYTE_ZERO;
      word_hold_lower <= `DCTPD_BYTE_ZERO;
      word_hold_upper <= `DCTPD_BYTE_ZERO;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `DCTPD_OFS_BHOLD_LO: byte_hold_low   <= reg_wdata_i;
        `DCTPD_OFS_BHOLD_HI: byte_hold_high  <= reg_wdata_i;
        `DCTPD_OFS_WHOLD_LO: word_hold_lower <= reg_wdata_i;
        `DCTPD_OFS_WHOLD_UP: word_hold_upper <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // byte counter
  // ----------------------------------------------------------------------
  assign byte_term = byte_run && byte_tick && (byte_cnt == `DCTPD_BYTE_ONE);
  assign byte_ev   = byte_term && (byte_single || !byte_first);

  // a loaded zero is never terminal: it simply wraps to ff
  always_ff @(posedge clk_i) begin
    if (rst_i || recover_i) begin
      byte_run   <= 1'b0;
      byte_first <= 1'b0;
      byte_wave  <= 1'b0;
      byte_cnt   <= `DCTPD_BYTE_ZERO;
    end else if (byte_start) begin
      byte_run   <= 1'b1;
      byte_first <= 1'b1;
      byte_wave  <= init8;
      byte_cnt   <= init8 ? byte_hold_high : byte_hold_low;
    end else if (byte_stop) begin
      byte_run <= 1'b0;
    end else if (byte_term) begin
      byte_wave  <= !byte_wave;
      byte_first <= 1'b0;
      if (byte_single) begin
        byte_run <= 1'b0;
        byte_cnt <= `DCTPD_BYTE_ZERO;
      end else begin
        byte_cnt <= byte_wave ? byte_hold_low : byte_hold_high;
      end
    end else if (byte_run && byte_tick) begin
      byte_cnt <= byte_cnt - `DCTPD_BYTE_ONE;
    end
  end

  // ----------------------------------------------------------------------
  // word counter
  // ----------------------------------------------------------------------
  assign word_hold = {word_hold_upper, word_hold_lower};
  assign rise      = demod_in_i && !demod_prev;
  assign fall      = !demod_in_i && demod_prev;
  assign qual      = (edge_sel[0] && rise) || (edge_sel[1] && fall);
  assign cap_any   = word_run_bit && demod_mode && qual &&
                     ((phase == dctpd_pkg::DCTPD_DM_FIRST) ||
                      ((phase == dctpd_pkg::DCTPD_DM_MEASURE) && !word_single));
  assign cap_later = cap_any && (phase == dctpd_pkg::DCTPD_DM_MEASURE);
  // counting from one into zero is the only timeout; zero to ffff is not
  assign word_ev   = word_run_bit && word_tick && !cap_any &&
                     (word_cnt == `DCTPD_WORD_ONE) &&
                     (!demod_mode || (phase == dctpd_pkg::DCTPD_DM_MEASURE));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      demod_prev <= 1'b0;
    end else begin
      demod_prev <= demod_in_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || recover_i) begin
      word_run_bit <= 1'b0;
      word_wave    <= 1'b0;
      word_cnt     <= `DCTPD_WORD_ZERO;
      capture_word <= `DCTPD_WORD_ZERO;
      phase        <= dctpd_pkg::DCTPD_DM_IDLE;
    end else if (word_start) begin
      word_run_bit <= 1'b1;
      word_cnt     <= word_hold;
      word_wave    <= init16;
      phase        <= demod_mode ? dctpd_pkg::DCTPD_DM_FIRST : dctpd_pkg::DCTPD_DM_IDLE;
    end else if (word_stop) begin
      word_run_bit <= 1'b0;
      phase        <= dctpd_pkg::DCTPD_DM_IDLE;
    end else if (cap_any) begin
      capture_word <= ~word_cnt;
      phase        <= dctpd_pkg::DCTPD_DM_MEASURE;
      word_cnt     <= cap_later ? `DCTPD_WORD_ONES : word_hold;
    end else if (word_ev && !demod_mode) begin
      word_wave <= !word_wave;
      if (word_single) begin
        word_run_bit <= 1'b0;
        word_cnt     <= `DCTPD_WORD_ZERO;
      end else begin
        word_cnt <= word_hold;
      end
    end else if (word_run_bit && word_tick &&
                 (!demod_mode || (phase == dctpd_pkg::DCTPD_DM_MEASURE))) begin
      word_cnt <= word_cnt - `DCTPD_WORD_ONE;
    end
  end

  // ----------------------------------------------------------------------
  // flags, set beats a same-cycle clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_tout <= 1'b0;
    end else begin
      byte_tout <= byte_ev || (byte_tout && !(wr_byte && reg_wdata_i[`DCTPD_B_TOUT]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || recover_i) begin
      word_tout      <= 1'b0;
      edge_rise_flag <= 1'b0;
      edge_fall_flag <= 1'b0;
    end else begin
      word_tout <= word_ev || (word_tout && !(wr_word && reg_wdata_i[`DCTPD_B_TOUT]));
      edge_rise_flag <= (cap_later && rise) ||
                        (edge_rise_flag && !(wr_shared && reg_wdata_i[`DCTPD_B_INIT16]));
      edge_fall_flag <= (cap_later && fall) ||
                        (edge_fall_flag && !(wr_shared && reg_wdata_i[`DCTPD_B_INIT8]));
    end
  end

  // one-cycle interrupt requests, each behind its mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_byte_timeout_o <= 1'b0;
      irq_word_timeout_o <= 1'b0;
      irq_capture_o      <= 1'b0;
    end else begin
      irq_byte_timeout_o <= byte_ev && byte_toutm;
      irq_word_timeout_o <= word_ev && word_toutm;
      irq_capture_o      <= cap_later && word_capm;
    end
  end

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  // force wins over everything; an idle transmitter parks at the inverse level
  always_comb begin
    if (wave_force[1]) begin
      wave_eff = wave_force[0];
    end else if (word_run_bit || demod_mode) begin
      wave_eff = word_wave;
    end else begin
      wave_eff = !init16;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_counter_wave_o <= 1'b0;
      word_counter_wave_o <= 1'b0;
      shared_port_pin_o   <= 1'b0;
    end else begin
      byte_counter_wave_o <= byte_wave;
      word_counter_wave_o <= wave_eff;
      shared_port_pin_o   <= wave_pin_route ? wave_eff : port_latch_i;
    end
  end

  // ----------------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = `DCTPD_BYTE_ZERO;
    case (reg_addr_i)
      `DCTPD_OFS_BYTE_CTL: next_rdata = {byte_run, byte_single, byte_tout, byte_rate,
                                         byte_capm, byte_toutm, 1'b0};
      `DCTPD_OFS_SHARED:   next_rdata = {1'b0, demod_mode, edge_sel, wave_force,
                                         demod_mode ? edge_fall_flag : init8,
                                         demod_mode ? edge_rise_flag : init16};
      `DCTPD_OFS_WORD_CTL: next_rdata = {word_run_bit, word_single, word_tout, word_rate,
                                         word_capm, word_toutm, wave_pin_route};
      `DCTPD_OFS_SYNC:     next_rdata = {word_run_bit, byte_run, sync_mode, 5'h00};
      `DCTPD_OFS_BHOLD_LO: next_rdata = byte_hold_low;
      `DCTPD_OFS_BHOLD_HI: next_rdata = byte_hold_high;
      `DCTPD_OFS_WHOLD_LO: next_rdata = word_hold_lower;
      `DCTPD_OFS_WHOLD_UP: next_rdata = word_hold_upper;
      `DCTPD_OFS_CAP_LO:   next_rdata = capture_word[7:0];
      `DCTPD_OFS_CAP_UP:   next_rdata = capture_word[15:8];
      default:             next_rdata = `DCTPD_BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `DCTPD_BYTE_ZERO;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence word_start_s;
    word_start && !recover_i;
  endsequence

  sequence word_loaded_s;
    word_run_bit && (word_counter_wave_o == init16 || wave_force[1]);
  endsequence

  word_start_a: assert property (word_start_s |=> word_cnt == word_hold ##1 word_loaded_s)
    else $error("word counter start load wrong");
  pin_route_a: assert property (##1 shared_port_pin_o ==
                                ($past(wave_pin_route) ? $past(wave_eff) : $past(port_latch_i)))
    else $error("shared pin source wrong");
  force_low_a: assert property (wave_force == `DCTPD_FORCE_LOW && !recover_i |=>
                                !word_counter_wave_o)
    else $error("forced low not seen");
  idle_level_a: assert property (!word_run_bit && !demod_mode && !wave_force[1] |=>
                                 word_counter_wave_o == !$past(init16))
    else $error("idle wave level wrong");
  word_flag_a: assert property (word_ev |=> word_tout ##1 (word_tout || $past(wr_word)))
    else $error("word timeout flag not set");
  word_irq_a: assert property (word_ev && !word_toutm |=> !irq_word_timeout_o)
    else $error("masked timeout interrupt raised");
  single_stop_a: assert property (word_ev && word_single && !demod_mode && !recover_i |=>
                                  !word_run_bit)
    else $error("single pass did not stop");
  capture_load_a: assert property (cap_later && !recover_i |=>
                                   word_cnt == `DCTPD_WORD_ONES && irq_capture_o == word_capm)
    else $error("capture reload wrong");
  byte_first_a: assert property (byte_term && byte_first && !byte_single |=>
                                 !irq_byte_timeout_o && !byte_ev)
    else $error("first modulo terminal interrupted");
  byte_reload_a: assert property (byte_term && !byte_single && !recover_i |=>
                                  byte_cnt == (byte_wave ? byte_hold_high : byte_hold_low))
    else $error("byte reload wrong");

endmodule

// ==== tb/dctpd_pin_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// far-side carrier source: four bursts, 20 cycles apart, then quiet
// ----------------------------------------------------------------------
module dctpd_pin_model (
  // clock and start
  input  wire logic clk_i,
  input  wire logic go_i,
  // demodulation pin
  output logic      carrier_o
);
  int unsigned cnt = 0;

  // pin moves at the falling edge so the design samples it settled
  always @(negedge clk_i) begin
    if (go_i && cnt < 80)
      cnt <= cnt + 1;
    carrier_o <= (cnt < 80) && (cnt % 20 >= 10);
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic       clk_i        = 1'b0;
  logic       rst_i        = 1'b1;
  logic       recover_i    = 1'b0;
  logic [3:0] reg_addr_i   = 4'h0;
  logic       reg_wr_i     = 1'b0;
  logic [7:0] reg_wdata_i  = 8'h00;
  logic       reg_rd_i     = 1'b0;
  logic       port_latch_i = 1'b0;
  logic       carrier_go   = 1'b0;
  logic       rd_seen      = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       demod_in_i;
  logic       byte_wave, word_wave, pin, irq_b, irq_w, irq_c;
  logic [7:0] exp_q[$];
  logic [7:0] shv[6]  = '{8'h00, 8'h01, 8'h08, 8'h0c, 8'h09, 8'h0d};
  logic       wexp[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0] d;
  int         mismatches = 0, checks_done = 0, seed = 46357, caps = 0;

  dctpd_top dctpd_top_i (.clk_i(clk_i), .rst_i(rst_i), .recover_i(recover_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .port_latch_i(port_latch_i),
    .demod_in_i(demod_in_i), .byte_counter_wave_o(byte_wave),
    .word_counter_wave_o(word_wave), .shared_port_pin_o(pin),
    .irq_byte_timeout_o(irq_b), .irq_word_timeout_o(irq_w), .irq_capture_o(irq_c));
  dctpd_pin_model dctpd_pin_model_i (.clk_i(clk_i), .go_i(carrier_go), .carrier_o(demod_in_i));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(negedge clk_i);
    reg_addr_i  = a;
    reg_wdata_i = v;
    reg_wr_i    = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  // the expected byte is queued here and judged by the watcher below
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_i);
    reg_rd_i = 1'b0;
  endtask
  task automatic results;
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // clock, watcher and watchdog
  // ----------------------------------------------------------------------
  initial forever #25 clk_i = ~clk_i;
  // read data lands one edge after the strobe, so judge it half a cycle later
  always @(posedge clk_i) rd_seen <= reg_rd_i;
  always @(negedge clk_i) begin
    if (rd_seen)
      check("read data", reg_rdata_o, exp_q.pop_front());
    if (irq_c)
      caps++;
  end
  initial begin
    #(50 * 3000);
    mismatches++;
    results;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    // random hold contents, then an unmapped place that must read zero
    for (int k = 4; k < 8; k++) begin
      d = 8'($random(seed));
      wr(k[3:0], d);
      rd(k[3:0], d);
    end
    wr(4'ha, d);
    rd(4'ha, 8'h00);
    // word modulo-N, count 3, every cycle, timeout mask on
    wr(4'h6, 8'h03);
    wr(4'h7, 8'h00);
    wr(4'h2, 8'h82);
    for (int i = 1; i <= 7; i++) begin
      @(negedge clk_i);
      check("word irq", irq_w, i == 3 || i == 6);
      check("word wave", word_wave, i >= 4 && i < 7);
    end
    rd(4'h2, 8'ha2);
    wr(4'h2, 8'h02);
    rd(4'h2, 8'h22);
    wr(4'h2, 8'h22);
    rd(4'h2, 8'h02);
    // idle level, force codes, wave routed to the shared pin
    wr(4'h2, 8'h01);
    foreach (shv[k]) begin
      wr(4'h1, shv[k]);
      repeat (3) @(negedge clk_i);
      check("word wave", word_wave, wexp[k]);
      check("shared pin", pin, wexp[k]);
    end
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h00);
    repeat (4) begin
      port_latch_i = 1'($random(seed));
      repeat (2) @(negedge clk_i);
      check("shared pin", pin, port_latch_i);
    end
    // byte single pass from the low hold
    wr(4'h4, 8'h03);
    wr(4'h0, 8'hc2);
    for (int i = 1; i <= 8; i++) begin
      @(negedge clk_i);
      check("byte irq", irq_b, i == 3);
      check("byte wave", byte_wave, i >= 4);
    end
    rd(4'h0, 8'h62);
    // demodulation on rising edges, capture mask on
    wr(4'h6, 8'hff);
    wr(4'h7, 8'hff);
    wr(4'h1, 8'h50);
    wr(4'h2, 8'h84);
    carrier_go = 1'b1;
    repeat (90) @(negedge clk_i);
    check("captures", caps[7:0], 8'h03);
    rd(4'h9, 8'h00);
    // rises are 20 cycles apart: 19 counts below ffff, complemented
    rd(4'h8, 8'h13);
    rd(4'h1, 8'h51);
    // recovery keeps rate and capture mask, drops route and timeout mask
    wr(4'h2, 8'h1f);
    @(negedge clk_i);
    recover_i = 1'b1;
    @(negedge clk_i);
    recover_i = 1'b0;
    rd(4'h2, 8'h1c);
    // sync mode: control run bits are ignored, the sync offset starts both
    wr(4'h3, 8'h20);
    wr(4'h2, 8'h80);
    rd(4'h3, 8'h20);
    wr(4'h3, 8'hc0);
    rd(4'h3, 8'hc0);
    repeat (2) @(negedge clk_i);
    results;
  end
endmodule
